// >>> dpo_lock_det.sv
// dpo_lock_det: one saturating fill/drain lock detector with hysteresis
// assumes sample_valid pulses once per error sample; hold comes from the mode, force from the mode or tied low
`timescale 1ns/1ps
module dpo_lock_det #(
    parameter int THR_W = 16
) (
    input  wire logic                          clk_sys,      // system clock
    input  wire logic                          rst,          // async reset, active high
    input  wire logic                          sample_valid, // one new error sample
    input  wire logic [dpo_pkg::ERR_W-1:0]     err_mag,      // absolute error, ps
    input  wire logic [THR_W-1:0]              threshold,    // lock threshold, ps
    input  wire logic [dpo_pkg::RATE_W-1:0]    fill_rate,    // fill bucket size
    input  wire logic [dpo_pkg::RATE_W-1:0]    drain_rate,   // drain bucket size
    input  wire logic                          force_unlock, // free-run or holdover
    input  wire logic                          hold,         // reference switchover
    output logic                               locked,       // lock indication
    output logic signed [dpo_pkg::LVL_W-1:0]   level         // current tub level
);
    typedef struct packed {
        logic signed [dpo_pkg::LVL_W-1:0] lvl; // tub level
        logic                             lck; // indication
    } dpo_ld_s;

    dpo_ld_s st_r;  // registered state
    dpo_ld_s st_nxt; // next state

    // wider sum so a full bucket at the rim cannot wrap
    logic signed [dpo_pkg::LVL_W+1:0] sum;

    // fill/drain and hysteresis
    always_comb begin
        st_nxt = st_r;
        sum    = {{2{st_r.lvl[dpo_pkg::LVL_W-1]}}, st_r.lvl};
        if (force_unlock) begin
            st_nxt.lck = 1'b0;
        end else if (hold) begin
            st_nxt = st_r;
        end else if (sample_valid) begin
            // fill when within threshold, else drain, never both
            if (err_mag <= {{(dpo_pkg::ERR_W-THR_W){1'b0}}, threshold}) begin
                sum = sum + $signed({7'h00, fill_rate});
            end else begin
                sum = sum - $signed({7'h00, drain_rate});
            end
            // clamp at the rims
            if (sum > $signed({{2{1'b0}}, dpo_pkg::LVL_FULL})) begin
                st_nxt.lvl = dpo_pkg::LVL_FULL;
            end else if (sum < $signed({{2{1'b1}}, dpo_pkg::LVL_EMPTY})) begin
                st_nxt.lvl = dpo_pkg::LVL_EMPTY;
            end else begin
                st_nxt.lvl = sum[dpo_pkg::LVL_W-1:0];
            end
            // hysteresis: hold between the marks
            if (st_nxt.lvl < dpo_pkg::LVL_LOW) begin
                st_nxt.lck = 1'b0;
            end else if (st_nxt.lvl > dpo_pkg::LVL_HIGH) begin
                st_nxt.lck = 1'b1;
            end
        end
    end

    // state register; empty and unlocked after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r.lvl <= dpo_pkg::LVL_EMPTY;
            st_r.lck <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign locked = st_r.lck;
    assign level  = st_r.lvl;
endmodule

// >>> dpo_phase_core.sv
// dpo_phase_core: closed-loop phase offset, slew limiting, digital pump and lock detectors
// assumes a byte-wide synchronous register port and TDC words already in picoseconds
`timescale 1ns/1ps
module dpo_phase_core (
    input  wire logic                                  clk_sys,        // system clock
    input  wire logic                                  rst,            // async reset
    // register port
    input  wire logic                                  reg_wr,         // byte write strobe
    input  wire logic                                  reg_rd,         // byte read strobe
    input  wire logic [11:0]                           reg_addr,       // byte address
    input  wire logic [7:0]                            reg_wdata,      // write data
    output logic      [7:0]                            reg_rdata,      // read data
    // multifunction pin triggers, one-cycle pulses
    input  wire logic                                  pin_inc,        // step up
    input  wire logic                                  pin_dec,        // step down
    input  wire logic                                  pin_clr,        // clear accumulator
    // time converter and feedback words, ps
    input  wire logic                                  sample_valid,   // new edge pair
    input  wire logic signed [dpo_pkg::ERR_W-1:0]      ref_time,       // reference edge time
    input  wire logic signed [dpo_pkg::ERR_W-1:0]      fb_time,        // feedback edge time
    input  wire logic signed [dpo_pkg::ERR_W-1:0]      period_diff,    // ref minus fb period
    // profile values
    input  wire logic [dpo_pkg::PHASE_THR_W-1:0]       phase_thr,      // phase lock threshold
    input  wire logic [dpo_pkg::FREQ_THR_W-1:0]        freq_thr,       // freq lock threshold
    input  wire logic [dpo_pkg::RATE_W-1:0]            phase_fill,     // phase fill bucket
    input  wire logic [dpo_pkg::RATE_W-1:0]            phase_drain,    // phase drain bucket
    input  wire logic [dpo_pkg::RATE_W-1:0]            freq_fill,      // freq fill bucket
    input  wire logic [dpo_pkg::RATE_W-1:0]            freq_drain,     // freq drain bucket
    // loop coefficients, fraction and exponent
    input  wire logic [dpo_pkg::COEF_FRAC_W-1:0]       coef_frac,      // fraction in [0,1)
    input  wire logic [dpo_pkg::COEF_EXP_W-1:0]        coef_nexp,      // negative exponent x
    input  wire logic [dpo_pkg::COEF_PEXP_W-1:0]       alpha_pexp0,    // alpha positive term 0
    input  wire logic [dpo_pkg::COEF_PEXP_W-1:0]       alpha_pexp1,    // alpha positive term 1
    input  wire logic                                  coef_is_alpha,  // use positive terms
    input  wire logic [1:0]                            pll_mode,       // dpo_mode_e code
    // results
    output logic signed [dpo_pkg::ERR_W-1:0]           applied_offset, // slewed total offset
    output logic signed [dpo_pkg::ERR_W-1:0]           phase_error,    // latest pump error
    output logic signed [dpo_pkg::ERR_W+7:0]           loop_error,     // integrator output
    output logic signed [dpo_pkg::ERR_W+7:0]           coef_scaled,    // error times coefficient
    output logic                                       phase_locked,   // phase lock indication
    output logic                                       freq_locked     // freq lock indication
);
    localparam int W = dpo_pkg::ERR_W;

    typedef struct packed {
        logic [dpo_pkg::OFS_W-1:0]    fixed_ofs;  // fixed offset
        logic [dpo_pkg::STEP_W-1:0]   step_size;  // step size
        logic [dpo_pkg::SLEW_W-1:0]   slew_limit; // slew limit, 0 = off
        logic signed [W-1:0]          incr_ofs;   // accumulated steps
        logic signed [W-1:0]          applied;    // offset in use
        logic signed [W-1:0]          err;        // pump output
        logic signed [W+7:0]          integ;      // integrator
        logic [7:0]                   rdata;      // read data register
    } dpo_core_s;

    dpo_core_s st_r;   // registered state
    dpo_core_s st_nxt; // next state

    logic signed [W-1:0] target;    // wanted total offset
    logic signed [W-1:0] delta;     // target minus applied
    logic signed [W-1:0] slew_step; // limit widened
    logic do_inc;                   // increment request from any source
    logic do_dec;                   // decrement request
    logic do_clr;                   // accumulator reset request
    logic signed [W-1:0] step_ext;  // step zero-extended
    logic signed [W-1:0] abs_ph;    // |phase error|
    logic signed [W-1:0] abs_fr;    // |period difference|
    logic signed [W+7:0] frac_prod; // coefficient product

    // register write decode and offset logic
    always_comb begin
        st_nxt    = st_r;
        do_inc    = pin_inc;
        do_dec    = pin_dec;
        do_clr    = pin_clr;
        step_ext  = $signed({{(W-dpo_pkg::STEP_W){1'b0}}, st_r.step_size});
        // byte writes into multi-byte registers
        if (reg_wr) begin
            for (int i = 0; i < dpo_pkg::FIXED_OFS_BYTES; i++) begin
                if (reg_addr == dpo_pkg::FIXED_OFS_ADDR + 12'(i)) begin
                    st_nxt.fixed_ofs[8*i +: 8] = reg_wdata;
                end
            end
            for (int i = 0; i < dpo_pkg::STEP_SIZE_BYTES; i++) begin
                if (reg_addr == dpo_pkg::STEP_SIZE_ADDR + 12'(i)) begin
                    st_nxt.step_size[8*i +: 8] = reg_wdata;
                end
            end
            for (int i = 0; i < dpo_pkg::SLEW_LIMIT_BYTES; i++) begin
                if (reg_addr == dpo_pkg::SLEW_LIMIT_ADDR + 12'(i)) begin
                    st_nxt.slew_limit[8*i +: 8] = reg_wdata;
                end
            end
            // control bits act once and are never stored, so they read back zero
            if (reg_addr == dpo_pkg::STEP_CTRL_ADDR) begin
                do_inc = do_inc | reg_wdata[dpo_pkg::INC_BIT];
                do_dec = do_dec | reg_wdata[dpo_pkg::DEC_BIT];
                do_clr = do_clr | reg_wdata[dpo_pkg::CLR_BIT];
            end
        end
        // accumulator: reset wins, inc and dec together cancel
        if (do_clr) begin
            st_nxt.incr_ofs = '0;
        end else if (do_inc && !do_dec) begin
            st_nxt.incr_ofs = st_r.incr_ofs + step_ext;
        end else if (do_dec && !do_inc) begin
            st_nxt.incr_ofs = st_r.incr_ofs - step_ext;
        end
        // fixed and incremental stay apart and only meet here
        target    = $signed(st_r.fixed_ofs) + st_r.incr_ofs;
        delta     = target - st_r.applied;
        slew_step = $signed({{(W-dpo_pkg::SLEW_W){1'b0}}, st_r.slew_limit});
        // limiter moves at most slew_limit ps per clock; zero means step at once
        if (st_r.slew_limit == '0) begin
            st_nxt.applied = target;
        end else if (delta > slew_step) begin
            st_nxt.applied = st_r.applied + slew_step;
        end else if (delta < -slew_step) begin
            st_nxt.applied = st_r.applied - slew_step;
        end else begin
            st_nxt.applied = target;
        end
        // digital pump and integrator on each edge pair
        if (sample_valid) begin
            st_nxt.err   = ref_time - fb_time - st_r.applied;
            st_nxt.integ = st_r.integ + (W+8)'(st_nxt.err);
        end
        // read data is registered: it answers one cycle after the strobe
        // and falls back to zero, so an unmapped or control address reads zero
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            for (int i = 0; i < dpo_pkg::FIXED_OFS_BYTES; i++) begin
                if (reg_addr == dpo_pkg::FIXED_OFS_ADDR + 12'(i)) begin
                    st_nxt.rdata = st_r.fixed_ofs[8*i +: 8];
                end
            end
            for (int i = 0; i < dpo_pkg::STEP_SIZE_BYTES; i++) begin
                if (reg_addr == dpo_pkg::STEP_SIZE_ADDR + 12'(i)) begin
                    st_nxt.rdata = st_r.step_size[8*i +: 8];
                end
            end
            for (int i = 0; i < dpo_pkg::SLEW_LIMIT_BYTES; i++) begin
                if (reg_addr == dpo_pkg::SLEW_LIMIT_ADDR + 12'(i)) begin
                    st_nxt.rdata = st_r.slew_limit[8*i +: 8];
                end
            end
        end
    end

    // coefficient scaling: fraction times 2^-x, alpha also times 2^(p0+p1)
    always_comb begin
        frac_prod = ((W+8)'(st_r.err) * $signed({1'b0, coef_frac})) >>> dpo_pkg::COEF_FRAC_W;
        frac_prod = frac_prod >>> coef_nexp;
        if (coef_is_alpha) begin
            frac_prod = frac_prod <<< alpha_pexp0;
            frac_prod = frac_prod <<< alpha_pexp1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r.fixed_ofs  <= dpo_pkg::FIXED_OFS_RST;
            st_r.step_size  <= dpo_pkg::STEP_SIZE_RST;
            st_r.slew_limit <= dpo_pkg::SLEW_LIMIT_RST;
            st_r.incr_ofs   <= '0;
            st_r.applied    <= '0;
            st_r.err        <= '0;
            st_r.integ      <= '0;
            st_r.rdata      <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // magnitudes for the detectors; most negative value is out of any threshold
    assign abs_ph = st_r.err[W-1] ? -st_r.err : st_r.err;
    assign abs_fr = period_diff[W-1] ? -period_diff : period_diff;

    // phase detector samples the pump output one cycle after it is formed;
    // the frequency detector takes period_diff straight from the port,
    // so the two indications may move one clock apart
    logic ph_valid_r; // delayed sample strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_valid_r <= 1'b0;
        end else begin
            ph_valid_r <= sample_valid;
        end
    end

    logic force_ul; // free-run or holdover
    logic in_switch; // reference switchover
    assign force_ul  = (pll_mode == 2'(dpo_pkg::DPO_MODE_FREE_RUN)) ||
                       (pll_mode == 2'(dpo_pkg::DPO_MODE_HOLDOVER));
    assign in_switch = (pll_mode == 2'(dpo_pkg::DPO_MODE_SWITCHING));

    // phase lock detector
    dpo_lock_det #(.THR_W(dpo_pkg::PHASE_THR_W)) u_phase_ld (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .sample_valid (ph_valid_r),
        .err_mag      (abs_ph),
        .threshold    (phase_thr),
        .fill_rate    (phase_fill),
        .drain_rate   (phase_drain),
        .force_unlock (force_ul),
        .hold         (in_switch),
        .locked       (phase_locked),
        .level        ()
    );

    // frequency lock detector on the period difference
    dpo_lock_det #(.THR_W(dpo_pkg::FREQ_THR_W)) u_freq_ld (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .sample_valid (sample_valid),
        .err_mag      (abs_fr),
        .threshold    (freq_thr),
        .fill_rate    (freq_fill),
        .drain_rate   (freq_drain),
        .force_unlock (1'b0),
        .hold         (in_switch),
        .locked       (freq_locked),
        .level        ()
    );

    assign reg_rdata      = st_r.rdata;
    assign applied_offset = st_r.applied;
    assign phase_error    = st_r.err;
    assign loop_error     = st_r.integ;
    assign coef_scaled    = frac_prod;
endmodule

// >>> dpo_phase_core_sva.sv
// dpo_phase_core_sva: port-level checks for the phase offset core
// assumes it is bound to dpo_phase_core and sees only its ports
`timescale 1ns/1ps
module dpo_phase_core_sva (
    input wire logic                             clk_sys,
    input wire logic                             rst,
    input wire logic                             reg_wr,
    input wire logic                             reg_rd,
    input wire logic [11:0]                      reg_addr,
    input wire logic [7:0]                       reg_wdata,
    input wire logic [7:0]                       reg_rdata,
    input wire logic                             sample_valid,
    input wire logic [1:0]                       pll_mode,
    input wire logic signed [dpo_pkg::ERR_W-1:0] applied_offset,
    input wire logic                             phase_locked,
    input wire logic                             freq_locked
);
    logic [dpo_pkg::SLEW_W-1:0] slew_r; // shadow of the slew limit
    // shadow the limit, the core keeps it internal
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slew_r <= dpo_pkg::SLEW_LIMIT_RST;
        end else if (reg_wr && reg_addr == dpo_pkg::SLEW_LIMIT_ADDR) begin
            slew_r[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == dpo_pkg::SLEW_LIMIT_ADDR + 12'h001) begin
            slew_r[15:8] <= reg_wdata;
        end
    end
    // one clock step stays inside plus or minus the limit
    function automatic logic step_ok(input logic signed [39:0] a, input logic signed [39:0] b,
                                     input logic [15:0] l);
        logic signed [40:0] d;
        d = a - b;
        step_ok = (d <= $signed({25'h0, l})) && (d >= -$signed({25'h0, l}));
    endfunction
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence in_switch;
        (pll_mode == 2'h3) [*3];
    endsequence
    sequence in_idle;
        (pll_mode == 2'h0 || pll_mode == 2'h2) [*2];
    endsequence
    chk_ctrl_reads_zero: assert property (
        reg_rd && reg_addr == dpo_pkg::STEP_CTRL_ADDR |=> reg_rdata == 8'h00)
        else $error("control byte read back nonzero");
    chk_reset_unlocked: assert property (
        $past(rst) |-> !phase_locked && !freq_locked)
        else $error("lock seen right after reset");
    chk_slew_bounded: assert property (
        slew_r != 16'h0000 && $stable(slew_r) |->
        step_ok(applied_offset, $past(applied_offset), slew_r))
        else $error("offset stepped past slew limit");
    chk_switch_hold: assert property (
        in_switch |-> $stable(phase_locked) && $stable(freq_locked))
        else $error("lock changed during switchover");
    chk_idle_unlock: assert property (
        in_idle |-> !phase_locked)
        else $error("phase lock shown in free-run or holdover");
    chk_phase_rise: assert property (
        $rose(phase_locked) |->
        $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("phase lock rose without a sample");
    chk_phase_fall: assert property (
        $fell(phase_locked) |-> $past(sample_valid) || $past(sample_valid, 2) ||
        $past(sample_valid, 3) || $past(pll_mode) == 2'h0 || $past(pll_mode) == 2'h2)
        else $error("phase lock fell without cause");
    chk_freq_change: assert property (
        $changed(freq_locked) |->
        $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("freq lock moved without a sample");
endmodule
bind dpo_phase_core dpo_phase_core_sva dpo_phase_core_sva_i (.clk_sys, .rst, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_valid, .pll_mode,
    .applied_offset, .phase_locked, .freq_locked);

// >>> dpo_phase_core_tb_top.sv
// dpo_phase_core_tb_top: register and sample driven checks of the core
// assumes the byte register port and pulse triggers of dpo_phase_core
`timescale 1ns/1ps
module dpo_phase_core_tb_top;
    logic               clk_sys, rst, reg_wr, reg_rd, sample_valid;
    logic [11:0]        reg_addr;
    logic [7:0]         reg_wdata, reg_rdata, rate;
    logic [2:0]         pins;       // inc, dec, clr triggers
    logic [23:0]        thr;        // shared lock threshold
    logic signed [39:0] ref_time, fb_time, period_diff, applied_offset, phase_error;
    logic signed [47:0] loop_error, coef_scaled;
    logic               alpha;      // selects the positive exponent terms
    logic [1:0]         pll_mode;
    logic               phase_locked, freq_locked;
    logic [39:0]        fx, fx2;    // fixed offsets under test
    logic [15:0]        st;         // step size under test
    int                 bad_count, compares;
    dpo_phase_core dpo_phase_core_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .pin_inc(pins[0]), .pin_dec(pins[1]), .pin_clr(pins[2]),
        .sample_valid, .ref_time, .fb_time, .period_diff, .phase_thr(thr[15:0]),
        .freq_thr(thr), .phase_fill(rate), .phase_drain(rate), .freq_fill(rate),
        .freq_drain(rate), .coef_frac(16'h8000), .coef_nexp(6'h01), .alpha_pexp0(3'h1),
        .alpha_pexp1(3'h0), .coef_is_alpha(alpha), .pll_mode, .applied_offset,
        .phase_error, .loop_error, .coef_scaled, .phase_locked, .freq_locked);
    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // byte write, strobe held for exactly one taking edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys) #1;
        reg_wr = 1'b0;
    endtask
    // byte read, data looked at in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk_sys) #1;
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys) #1;
        pins[k] = 1'b1;
        @(posedge clk_sys) #1;
        pins = 3'h0;
    endtask
    // n samples of error e and period difference pd, then let the lock settle
    task automatic samp(input int n, input logic [39:0] e, input logic [39:0] pd);
        repeat (n) begin
            @(posedge clk_sys) #1;
            sample_valid = 1'b1;
            ref_time = e + e;
            fb_time = e;
            period_diff = pd;
            @(posedge clk_sys) #1;
            sample_valid = 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    // allow the offset pipeline to land, then compare
    task automatic ofs(input logic [39:0] e);
        repeat (4) @(posedge clk_sys);
        #1;
        chk(applied_offset, e);
    endtask
    task automatic finish_test;
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, the tests need under ten microseconds
    initial begin
        #60000;
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        {rst, reg_wr, reg_rd, sample_valid, reg_addr, reg_wdata, pins} = '0;
        {ref_time, fb_time, period_diff} = '0;
        rst = 1'b1;
        pll_mode = 2'h1;
        alpha = 1'b0;
        rate = 8'h40;
        thr = 24'd100;
        fx = 40'hff_ffff_ff00;
        fx2 = 40'hff_ffff_ff40;
        st = 16'h0030;
        bad_count = 0;
        compares = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(applied_offset, 40'h0);
        rd(dpo_pkg::FIXED_OFS_ADDR, 8'h00);
        $display("test reset done");
        samp(48, 40'h0, 40'h0);
        chk({phase_locked, freq_locked}, 40'h0);
        samp(1, 40'h0, 40'h0);
        chk({phase_locked, freq_locked}, 40'h3);
        samp(33, 40'd1000, 40'd1000);
        chk({phase_locked, freq_locked}, 40'h3);
        chk(phase_error, 40'd1000);
        chk(loop_error[39:0], 40'd33000);
        chk(coef_scaled[39:0], 40'd250);
        alpha = 1'b1;
        @(posedge clk_sys) #1;
        chk(coef_scaled[39:0], 40'd500);
        samp(1, 40'd1000, 40'd1000);
        chk({phase_locked, freq_locked}, 40'h0);
        samp(34, -40'sd100, -40'sd100);
        chk({phase_locked, freq_locked}, 40'h3);
        samp(20, 40'h0, 40'h0);
        pll_mode = 2'h3;
        samp(60, 40'd1000, 40'd1000);
        chk({phase_locked, freq_locked}, 40'h3);
        pll_mode = 2'h2;
        ofs(40'h0);
        chk({phase_locked, freq_locked}, 40'h1);
        pll_mode = 2'h0;
        ofs(40'h0);
        chk(phase_locked, 40'h0);
        pll_mode = 2'h1;
        $display("test lock detectors done");
        for (int i = 0; i < 5; i++) wr(dpo_pkg::FIXED_OFS_ADDR + 12'(i), fx[8*i+:8]);
        for (int i = 0; i < 5; i++) rd(dpo_pkg::FIXED_OFS_ADDR + 12'(i), fx[8*i+:8]);
        for (int i = 0; i < 2; i++) wr(dpo_pkg::STEP_SIZE_ADDR + 12'(i), st[8*i+:8]);
        rd(dpo_pkg::STEP_SIZE_ADDR + 12'h001, st[15:8]);
        ofs(fx);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h01);
        ofs(fx + 40'(st));
        rd(dpo_pkg::STEP_CTRL_ADDR, 8'h00);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h02);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h02);
        ofs(fx - 40'(st));
        pulse(0);
        ofs(fx);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h03);
        ofs(fx);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h01);
        wr(dpo_pkg::STEP_CTRL_ADDR, 8'h04);
        ofs(fx);
        pulse(1);
        ofs(fx - 40'(st));
        pulse(2);
        ofs(fx);
        rd(12'h000, 8'h00);
        $display("test offsets done");
        wr(dpo_pkg::SLEW_LIMIT_ADDR, 8'h04);
        wr(dpo_pkg::FIXED_OFS_ADDR, fx2[7:0]);
        ofs(fx + 40'd16);
        repeat (20) @(posedge clk_sys);
        #1;
        chk(applied_offset, fx2);
        $display("test slew done");
        finish_test();
    end
endmodule

// >>> dpo_pkg.sv
// dpo_pkg: register offsets, field layouts, widths and lock detector constants
// assumes a byte-addressed register port with one register byte per address
package dpo_pkg;
    // register byte offsets (low byte of multi-byte registers)
    localparam logic [11:0] FIXED_OFS_ADDR    = 12'h30f; // 5 bytes, 0x30f..0x313
    localparam logic [11:0] STEP_SIZE_ADDR    = 12'h314; // 2 bytes, 0x314..0x315
    localparam logic [11:0] SLEW_LIMIT_ADDR   = 12'h316; // 2 bytes, 0x316..0x317
    localparam logic [11:0] STEP_CTRL_ADDR    = 12'ha0c; // self-clearing control byte
    localparam int          FIXED_OFS_BYTES   = 5;
    localparam int          STEP_SIZE_BYTES   = 2;
    localparam int          SLEW_LIMIT_BYTES  = 2;
    // control byte fields
    localparam int          INC_BIT           = 0;
    localparam int          DEC_BIT           = 1;
    localparam int          CLR_BIT           = 2;
    // widths
    localparam int          OFS_W             = 40;
    localparam int          STEP_W            = 16;
    localparam int          SLEW_W            = 16;
    localparam int          PHASE_THR_W       = 16;
    localparam int          FREQ_THR_W        = 24;
    localparam int          RATE_W            = 8;
    localparam int          ERR_W             = 40;
    localparam int          LVL_W             = 13;
    // reset values
    localparam logic [OFS_W-1:0]  FIXED_OFS_RST  = 40'h00_0000_0000;
    localparam logic [STEP_W-1:0] STEP_SIZE_RST  = 16'h0000;
    localparam logic [SLEW_W-1:0] SLEW_LIMIT_RST = 16'h0000;
    // lock detector level marks
    localparam logic signed [LVL_W-1:0] LVL_EMPTY = -13'sd2048;
    localparam logic signed [LVL_W-1:0] LVL_FULL  = 13'sd2048;
    localparam logic signed [LVL_W-1:0] LVL_LOW   = -13'sd1024;
    localparam logic signed [LVL_W-1:0] LVL_HIGH  = 13'sd1024;
    // loop coefficient fields
    localparam int          COEF_FRAC_W       = 16;
    localparam int          COEF_EXP_W        = 6;
    localparam int          COEF_PEXP_W       = 3;
    // pll operating mode
    typedef enum logic [1:0] {
        DPO_MODE_FREE_RUN,
        DPO_MODE_CLOSED,
        DPO_MODE_HOLDOVER,
        DPO_MODE_SWITCHING
    } dpo_mode_e;
endpackage
